//--- src/aba_core.sv
// block cipher accelerator: key load, key schedule, rounds, result fifo
// assumes a word-write source and a drain with valid/ready, one clock
`timescale 1ns/1ns
`include "aba_defs.svh"
module aba_core (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  aba_pkg::aba_wr_t      wr,
  input  wire logic             start,
  input  wire logic             decrypt,
  input  wire logic             key256,
  output logic                  busy,
  output logic                  done,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [31:0]           rd_data
);
  aba_pkg::aba_state_t s_r;
  aba_pkg::aba_state_t s_nxt;
  logic                push_valid;
  logic                push_ready;
  logic [31:0]         push_data;
  logic [6:0]          lat;

  // ==========================================================
  // field arithmetic
  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int k = 0; k < 8; k++) begin
      if (b[k]) p = p ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1b : 8'h00);
    end
    return p;
  endfunction : gmul

  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] p;
    logic [7:0] e;
    r = 8'h01;
    p = a;
    e = 8'hfe;
    for (int k = 0; k < 8; k++) begin
      if (e[k]) r = gmul(r, p);
      p = gmul(p, p);
    end
    return r;
  endfunction : ginv

  function automatic logic [7:0] sbox(input logic [7:0] a, input logic inv);
    logic [7:0] t;
    t = 8'h00;
    if (inv) begin
      t = {a[6:0], a[7]} ^ {a[4:0], a[7:5]} ^ {a[1:0], a[7:2]} ^ 8'h05;
      t = ginv(t);
    end else begin
      t = ginv(a);
      t = t ^ {t[6:0], t[7]} ^ {t[5:0], t[7:6]} ^ {t[4:0], t[7:5]} ^ {t[3:0], t[7:4]} ^ 8'h63;
    end
    return t;
  endfunction : sbox

  // ==========================================================
  // block transforms
  function automatic logic [127:0] sub_blk(input logic [127:0] b, input logic inv);
    logic [127:0] o;
    o = '0;
    for (int k = 0; k < 16; k++) begin
      o[127-8*k -: 8] = sbox(b[127-8*k -: 8], inv);
    end
    return o;
  endfunction : sub_blk

  function automatic logic [127:0] shift_blk(input logic [127:0] b, input logic inv);
    logic [127:0] o;
    int           src;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        src = inv ? (r + 4 * ((c - r + 4) % 4)) : (r + 4 * ((c + r) % 4));
        o[127-8*(r+4*c) -: 8] = b[127-8*src -: 8];
      end
    end
    return o;
  endfunction : shift_blk

  function automatic logic [127:0] mix_blk(input logic [127:0] b, input logic inv);
    logic [127:0]     o;
    logic [3:0][7:0]  m;
    logic [7:0]       acc;
    o = '0;
    m = inv ? {8'h0e, 8'h0b, 8'h0d, 8'h09} : {8'h02, 8'h03, 8'h01, 8'h01};
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        acc = 8'h00;
        for (int j = 0; j < 4; j++) begin
          acc = acc ^ gmul(b[127-8*(4*c+(r+j)%4) -: 8], m[3-j]);
        end
        o[127-8*(4*c+r) -: 8] = acc;
      end
    end
    return o;
  endfunction : mix_blk

  // ==========================================================
  // sequencer
  assign lat        = s_r.k256 ? `ABA_LAT_K256 : `ABA_LAT_K128;
  assign wr_ready   = (s_r.phase == aba_pkg::ABA_IDLE) && !start;
  assign busy       = s_r.busy;
  assign done       = s_r.done;
  assign push_valid = (s_r.phase == aba_pkg::ABA_OUT);
  assign push_data  = s_r.blk[127-32*s_r.oidx -: 32];

  always_comb begin
    logic [127:0] prev;
    logic [127:0] prev2;
    logic [127:0] b;
    logic [31:0]  t;
    logic         even;
    prev  = '0;
    prev2 = '0;
    b     = '0;
    t     = '0;
    even  = 1'b0;
    s_nxt = s_r;
    case (s_r.phase)
      aba_pkg::ABA_IDLE: begin
        if (wr_valid && wr_ready) begin
          if (wr.sel == `ABA_SEL_KEY) begin
            s_nxt.key[32*(7-int'(wr.idx)) +: 32] = wr.data;
          end else begin
            s_nxt.blk[32*(3-int'(wr.idx[1:0])) +: 32] = wr.data;
          end
        end
        if (start) begin
          s_nxt.phase = aba_pkg::ABA_EXPAND;
          s_nxt.busy  = 1'b1;
          s_nxt.done  = 1'b0;
          s_nxt.cnt   = 7'd0;
          s_nxt.dec   = decrypt;
          s_nxt.k256  = key256;
          s_nxt.nr    = key256 ? `ABA_NR_K256 : `ABA_NR_K128;
          s_nxt.rk[0] = s_r.key[255:128];
          s_nxt.rk[1] = s_r.key[127:0];
          s_nxt.i     = key256 ? 4'd2 : 4'd1;
          s_nxt.rcon  = `ABA_RCON_INIT;
        end
      end
      aba_pkg::ABA_EXPAND: begin
        s_nxt.cnt = s_r.cnt + 7'd1;
        prev  = s_r.rk[s_r.i - 4'd1];
        prev2 = s_r.k256 ? s_r.rk[s_r.i - 4'd2] : prev;
        even  = !s_r.k256 || !s_r.i[0];
        t     = even ? {prev[23:0], prev[31:24]} : prev[31:0];
        t     = {sbox(t[31:24], 1'b0), sbox(t[23:16], 1'b0), sbox(t[15:8], 1'b0), sbox(t[7:0], 1'b0)};
        if (even) begin
          t          = t ^ {s_r.rcon, 24'h000000};
          s_nxt.rcon = {s_r.rcon[6:0], 1'b0} ^ (s_r.rcon[7] ? 8'h1b : 8'h00);
        end
        b[127:96] = prev2[127:96] ^ t;
        b[95:64]  = prev2[95:64] ^ b[127:96];
        b[63:32]  = prev2[63:32] ^ b[95:64];
        b[31:0]   = prev2[31:0] ^ b[63:32];
        s_nxt.rk[s_r.i] = b;
        s_nxt.i         = s_r.i + 4'd1;
        if (s_r.i == s_r.nr) begin
          s_nxt.phase = aba_pkg::ABA_ROUND;
          s_nxt.i     = 4'd0;
        end
      end
      aba_pkg::ABA_ROUND: begin
        s_nxt.cnt = s_r.cnt + 7'd1;
        s_nxt.i   = s_r.i + 4'd1;
        if (s_r.i == 4'd0) begin
          s_nxt.blk = s_r.blk ^ (s_r.dec ? s_r.rk[s_r.nr] : s_r.rk[0]);
        end else if (s_r.dec) begin
          b = sub_blk(shift_blk(s_r.blk, 1'b1), 1'b1) ^ s_r.rk[s_r.nr - s_r.i];
          s_nxt.blk = (s_r.i == s_r.nr) ? b : mix_blk(b, 1'b1);
        end else begin
          b = shift_blk(sub_blk(s_r.blk, 1'b0), 1'b0);
          if (s_r.i != s_r.nr) b = mix_blk(b, 1'b0);
          s_nxt.blk = b ^ s_r.rk[s_r.i];
        end
        if (s_r.i == s_r.nr) begin
          s_nxt.phase = aba_pkg::ABA_WAIT;
        end
      end
      aba_pkg::ABA_WAIT: begin
        s_nxt.cnt = s_r.cnt + 7'd1;
        if (s_r.cnt == lat - 7'd1) begin
          s_nxt.phase = aba_pkg::ABA_OUT;
          s_nxt.done  = 1'b1;
          s_nxt.oidx  = 2'd0;
        end
      end
      aba_pkg::ABA_OUT: begin
        if (push_ready) begin
          s_nxt.oidx = s_r.oidx + 2'd1;
          if (s_r.oidx == 2'd3) begin
            s_nxt.phase = aba_pkg::ABA_IDLE;
            s_nxt.busy  = 1'b0;
          end
        end
      end
      default: begin
        s_nxt.phase = aba_pkg::ABA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // result buffer
  aba_fifo #(
    .W (`ABA_WORD_W),
    .D (`ABA_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );
endmodule : aba_core

//--- src/aba_defs.svh
// constants of the block cipher accelerator: latencies, round counts, fifo size
// assumes inclusion by the package and aba_core
`ifndef ABA_DEFS_SVH
`define ABA_DEFS_SVH
`define ABA_LAT_K128   7'd52
`define ABA_LAT_K256   7'd75
`define ABA_NR_K128    4'd10
`define ABA_NR_K256    4'd14
`define ABA_WORD_W     32
`define ABA_FIFO_DEPTH 16
`define ABA_SEL_DATA   1'b0
`define ABA_SEL_KEY    1'b1
`define ABA_RCON_INIT  8'h01
`endif

//--- src/aba_pkg.sv
// types of the block cipher accelerator
// assumes aba_defs.svh on the include path
`include "aba_defs.svh"
package aba_pkg;
  // ==========================================================
  // sequencer phases
  typedef enum logic [2:0] {
    ABA_IDLE   = 3'b000,
    ABA_EXPAND = 3'b001,
    ABA_ROUND  = 3'b010,
    ABA_WAIT   = 3'b011,
    ABA_OUT    = 3'b100
  } aba_phase_t;

  // ==========================================================
  // word write into key or data store
  typedef struct packed {
    logic        sel;
    logic [2:0]  idx;
    logic [31:0] data;
  } aba_wr_t;

  // ==========================================================
  // state of the cipher core sequencer, without the result fifo, which holds its own
  typedef struct packed {
    aba_phase_t         phase;
    logic [255:0]       key;
    logic [127:0]       blk;
    logic [14:0][127:0] rk;
    logic [3:0]         i;
    logic [3:0]         nr;
    logic [7:0]         rcon;
    logic [6:0]         cnt;
    logic [1:0]         oidx;
    logic               dec;
    logic               k256;
    logic               busy;
    logic               done;
  } aba_state_t;
endpackage : aba_pkg

//--- src/aba_fifo.sv
// result fifo, parameterised width and depth, valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ns
module aba_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } aba_fifo_st_t;

  aba_fifo_st_t s_r;
  aba_fifo_st_t s_nxt;
  logic         push;
  logic         pop;

  // ==========================================================
  // handshake
  assign in_ready  = (s_r.cnt != (AW+1)'(D));
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ==========================================================
  // pointers and storage
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp          = (s_r.wp == AW'(D-1)) ? '0 : s_r.wp + AW'(1);
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(D-1)) ? '0 : s_r.rp + AW'(1);
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : aba_fifo

//--- verification/aba_core_properties.sv
// port checker of the cipher core
// assumes binding to every aba_core instance
`timescale 1ns/1ns
module aba_core_properties (
  input wire logic         clk,
  input wire logic         reset_n,
  input wire logic         start,
  input wire logic         key256,
  input wire logic         busy,
  input wire logic         done,
  input wire logic         wr_ready,
  input wire logic         rd_valid,
  input wire logic         rd_ready,
  input wire logic [31:0]  rd_data
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_lat_short: assert property (start && !busy && !key256 |-> ##53 $rose(done))
    else $error("done not on time, short key");
  a_lat_long: assert property (start && !busy && key256 |-> ##76 $rose(done))
    else $error("done not on time, long key");
  a_start_take: assert property (start && !busy |=> busy && !done)
    else $error("start not taken");
  a_busy_hold: assert property (start && !busy |=> busy [*8])
    else $error("busy dropped early");
  a_busy_end: assert property ($fell(busy) |-> done)
    else $error("busy fell without done");
  a_done_keep: assert property (done && !(start && !busy) |=> done)
    else $error("done lost");
  a_wr_shut: assert property (busy || start |-> !wr_ready)
    else $error("write open while busy");
  a_wr_open: assert property (!busy && !start |-> wr_ready)
    else $error("write shut while idle");
  a_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("result word not held");
endmodule : aba_core_properties

bind aba_core aba_core_properties u_props (.clk, .reset_n, .start, .key256, .busy, .done, .wr_ready,
  .rd_valid, .rd_ready, .rd_data);

//--- verification/aba_sink.sv
// result drain model: prompt, slow or stopped
// assumes the core's rd port on one clock
`timescale 1ns/1ns
module aba_sink (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hold,
  input  wire logic        slow,
  input  wire logic        rd_valid,
  input  wire logic [31:0] rd_data,
  output logic             rd_ready
);
  logic [31:0] got[$];
  logic        tgl_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tgl_r <= 1'b0;
    else tgl_r <= ~tgl_r;
  end
  assign rd_ready = !hold && (!slow || tgl_r);
  always @(posedge clk) begin
    if (reset_n && rd_valid && rd_ready) got.push_back(rd_data);
  end
endmodule : aba_sink

//--- verification/tb_aba_core.sv
// testbench of the cipher core
// assumes aba_core, aba_sink and the checker compiled before
`timescale 1ns/1ns
module tb_aba_core;
  localparam logic [255:0] K128 = {128'h000102030405060708090a0b0c0d0e0f, 128'h0};
  localparam logic [255:0] K256 = 256'h000102030405060708090a0b0c0d0e0f101112131415161718191a1b1c1d1e1f;
  localparam logic [127:0] PT = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] CT1 = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
  localparam logic [127:0] CT2 = 128'h8ea2b7ca516745bfeafc49904b496089;
  logic clk, reset_n, wr_valid, wr_ready, start, decrypt, key256, busy, done, rd_valid, rd_ready, hold, slow;
  logic [31:0] rd_data;
  aba_pkg::aba_wr_t wr;
  int err_count, checked;

  aba_core u_dut (.clk, .reset_n, .wr_valid, .wr_ready, .wr, .start, .decrypt, .key256, .busy, .done,
    .rd_valid, .rd_ready, .rd_data);
  aba_sink u_sink (.clk, .reset_n, .hold, .slow, .rd_valid, .rd_data, .rd_ready);

  // ==========================================================
  // shared tasks
  task chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task stop_test;
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task put(input logic s, input logic [2:0] i, input logic [31:0] d);
    wr_valid <= 1'b1;
    wr <= {s, i, d};
    @(posedge clk);
    while (wr_ready !== 1'b1) @(posedge clk);
  endtask : put
  task load(input logic [255:0] k, input int nk);
    @(posedge clk);
    for (int i = 0; i < nk; i++) put(1'b1, 3'(i), k[255-32*i -: 32]);
    for (int i = 0; i < 4; i++) put(1'b0, 3'(i), PT[127-32*i -: 32]);
    wr_valid <= 1'b0;
  endtask : load
  task go(input logic d, input logic k, input int lat, input logic poke);
    int n;
    @(posedge clk);
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("idle before start", 0, busy);
    start <= 1'b1;
    decrypt <= d;
    key256 <= k;
    @(posedge clk);
    start <= poke;
    wr_valid <= poke;
    wr <= {1'b0, 3'd0, 32'hdeadbeef};
    #1;
    chk("busy", 1, busy);
    chk("done", 0, done);
    @(posedge clk);
    start <= 1'b0;
    wr_valid <= 1'b0;
    #1;
    n = 1;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("latency", lat, n);
  endtask : go
  task drain(input logic [127:0] exp, input int w);
    int n;
    n = 0;
    while (u_sink.got.size() < w && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("words", w, u_sink.got.size());
    for (int i = 0; i < w; i++) chk("word", exp[127-32*(i%4) -: 32], u_sink.got[i]);
    u_sink.got.delete();
  endtask : drain

  // ==========================================================
  // scenarios
  task t_long;
    load(K256, 8);
    go(1'b0, 1'b1, 75, 1'b0);
    drain(CT2, 4);
    go(1'b1, 1'b1, 75, 1'b0);
    drain(PT, 4);
  endtask : t_long
  task t_short;
    load(K128, 4);
    go(1'b0, 1'b0, 52, 1'b1);
    drain(CT1, 4);
    go(1'b1, 1'b0, 52, 1'b0);
    drain(PT, 4);
  endtask : t_short
  task t_fifo;
    @(posedge clk);
    hold <= 1'b1;
    repeat (5) begin
      load(K128, 4);
      go(1'b0, 1'b0, 52, 1'b0);
    end
    repeat (8) @(posedge clk);
    #1;
    chk("busy stalled", 1, busy);
    @(posedge clk);
    hold <= 1'b0;
    slow <= 1'b1;
    drain(CT1, 20);
  endtask : t_fifo

  // ==========================================================
  // clock, reset, sequence, watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    wr_valid = 1'b0;
    wr = '0;
    start = 1'b0;
    decrypt = 1'b0;
    key256 = 1'b0;
    hold = 1'b0;
    slow = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    chk("reset state", 4'h1, {busy, done, rd_valid, wr_ready});
    reset_n <= 1'b1;
    t_long;
    t_short;
    t_fifo;
    stop_test;
  end
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
endmodule : tb_aba_core
